//--- dv/fhbc_asserts.sv
`timescale 1ns/1ns
module fhbc_asserts (
	// Clock and reset
	input wire       CLK_SYS,
	input wire       RESET,
	// Register port
	input wire [3:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR,
	input wire       RD,
	input wire [7:0] RDATA,
	input wire       INT_N,
	// Link
	input wire       TX_BIT_REQ,
	input wire       TX_BIT,
	input wire       RX_BIT_VALID,
	input wire       RX_BIT
);
	reg [7:0] ctl_q;
	reg [7:0] mask_q;
	always @(posedge CLK_SYS) begin
		if (RESET) begin
			ctl_q  <= 8'h00;
			mask_q <= 8'h00;
		end else if (WR && ADDR == 4'h0) begin
			ctl_q <= WDATA;
		end else if (WR && ADDR == 4'h2) begin
			mask_q <= WDATA;
		end
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	sequence s_ctl_wr;
		WR && ADDR == 4'h0;
	endsequence
	sequence s_rx_rst;
		WR && ADDR == 4'h0 && WDATA[6] && !ctl_q[6];
	endsequence
	sequence s_tx_rst;
		WR && ADDR == 4'h0 && WDATA[4] && !ctl_q[4];
	endsequence
	a_reset_state:
		assert property (disable iff (1'b0)
			RESET |=> RDATA == 8'h00 && INT_N && TX_BIT)
		else $error("outputs not at reset values");
	a_rdata_hold:
		assert property (!RD |=> $stable(RDATA))
		else $error("read data changed without a read");
	// A transmit reset forces the link bit high without a request.
	a_tx_bit_hold:
		assert property (!TX_BIT_REQ && !(ctl_q[4] && !$past(ctl_q[4]))
			|=> $stable(TX_BIT))
		else $error("link bit changed without a request");
	a_ctl_readback:
		assert property (s_ctl_wr ##1 !WR ##1 (RD && ADDR == 4'h0)
			|=> (RDATA & 8'hfb) == ($past(WDATA, 3) & 8'hfb))
		else $error("control bits not held as written");
	a_int_mask_off:
		assert property (WR && ADDR == 4'h2 && WDATA == 8'h00
			|-> ##3 INT_N)
		else $error("interrupt low with all events masked");
	a_int_cause:
		assert property ($fell(INT_N) |-> $past(mask_q) != 8'h00)
		else $error("interrupt fell with no event enabled");
	a_rx_reset_empty:
		assert property (s_rx_rst ##3 (RD && ADDR == 4'h3) |=> RDATA[7])
		else $error("receive queue not empty after its reset");
	a_tx_reset_code:
		assert property (s_tx_rst ##1 !WR ##2 (RD && ADDR == 4'h7)
			|=> !RDATA[7])
		else $error("code sending survived transmit reset");
endmodule // fhbc_asserts

bind fhbc_controller fhbc_asserts u_asserts (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .INT_N(INT_N),
	.TX_BIT_REQ(TX_BIT_REQ), .TX_BIT(TX_BIT),
	.RX_BIT_VALID(RX_BIT_VALID), .RX_BIT(RX_BIT)
);

//--- dv/fhbc_controller_bench.sv
`timescale 1ns/1ns
module fhbc_controller_bench;
	reg        clk_sys = 1'b0;
	reg        reset = 1'b1;
	reg  [3:0] addr = 4'h0;
	reg  [7:0] wdata = 8'h00;
	reg        wr = 1'b0;
	reg        rd = 1'b0;
	reg        slow = 1'b0;
	reg  [7:0] zeros = 8'h00;
	reg  [7:0] z0;
	wire [7:0] rdata;
	wire       int_n;
	wire       req;
	wire       tx_bit;
	wire       rx_vld;
	wire       rx_bit;
	integer    err_count = 0;
	integer    tests_run = 0;
	always #20 clk_sys = ~clk_sys;
	fhbc_controller u_dut (
		.CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .INT_N(int_n),
		.TX_BIT_REQ(req), .TX_BIT(tx_bit),
		.RX_BIT_VALID(rx_vld), .RX_BIT(rx_bit)
	);
	fhbc_link_model u_link (
		.clk(clk_sys), .rst(reset), .slow(slow), .tx_bit_req(req),
		.tx_bit(tx_bit), .rx_bit_valid(rx_vld), .rx_bit(rx_bit)
	);
	always @(posedge clk_sys) begin
		if (rx_vld && rx_bit === 1'b0)
			zeros <= zeros + 8'h01;
	end
	task print_verdict;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input [95:0] name, input [7:0] exp, input [7:0] got);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("mismatch %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task idle(input integer n);
		begin
			repeat (n) @(negedge clk_sys);
		end
	endtask
	task wr_reg(input [3:0] a, input [7:0] d);
		begin
			@(negedge clk_sys);
			addr = a;
			wdata = d;
			wr = 1'b1;
			@(negedge clk_sys);
			wr = 1'b0;
		end
	endtask
	task rd_chk(input [3:0] a, input [7:0] m, input [7:0] e,
		input [95:0] name);
		begin
			@(negedge clk_sys);
			addr = a;
			rd = 1'b1;
			@(negedge clk_sys);
			rd = 1'b0;
			chk(name, e, rdata & m);
		end
	endtask
	task wait_int;
		integer n;
		begin
			n = 0;
			while (int_n !== 1'b0 && n < 3000) begin
				@(negedge clk_sys);
				n = n + 1;
			end
			chk("int low", 8'h00, {7'h00, int_n});
		end
	endtask
	initial begin
		#1000000;
		err_count = err_count + 1;
		print_verdict;
	end
	initial begin
		idle(16);
		reset = 1'b0;
		chk("int idle", 8'h01, {7'h00, int_n});
		rd_chk(4'h0, 8'hff, 8'h00, "control");
		rd_chk(4'h2, 8'hff, 8'h00, "mask");
		rd_chk(4'hf, 8'hff, 8'h00, "unmapped");
		wr_reg(4'h7, 8'h40);
		wr_reg(4'h0, 8'h20);
		idle(64);
		z0 = zeros;
		idle(100);
		chk("ff idle", 8'h00, zeros - z0);
		wr_reg(4'h0, 8'h28);
		rd_chk(4'h0, 8'hff, 8'h28, "control");
		idle(200);
		chk("abort", 8'h01, zeros - z0);
		z0 = zeros;
		wr_reg(4'h0, 8'h28);
		idle(200);
		chk("held abort", 8'h00, zeros - z0);
		wr_reg(4'h0, 8'h00);
		idle(64);
		z0 = zeros;
		idle(128);
		chk("flags", 8'h08, zeros - z0);
		wr_reg(4'h0, 8'h40);
		idle(1);
		rd_chk(4'h3, 8'h80, 8'h80, "rx reset");
		wr_reg(4'h0, 8'h00);
		slow = 1'b1;
		rd_chk(4'h6, 8'h80, 8'h80, "tx empty");
		wr_reg(4'h2, 8'h01);
		wr_reg(4'h8, 8'h3c);
		wr_reg(4'h0, 8'h04);
		wr_reg(4'h8, 8'h7e);
		wait_int;
		rd_chk(4'h0, 8'hff, 8'h00, "control");
		rd_chk(4'h1, 8'h01, 8'h01, "msg done");
		rd_chk(4'h1, 8'h01, 8'h00, "msg done");
		chk("int clear", 8'h01, {7'h00, int_n});
		rd_chk(4'h6, 8'h20, 8'h00, "underrun");
		idle(60);
		rd_chk(4'h3, 8'he0, 8'h40, "rx first");
		rd_chk(4'h5, 8'hff, 8'h3c, "rx byte");
		rd_chk(4'h3, 8'hf0, 8'h30, "rx last");
		rd_chk(4'h5, 8'hff, 8'h7e, "rx byte");
		rd_chk(4'h3, 8'h80, 8'h80, "rx empty");
		slow = 1'b0;
		wr_reg(4'h0, 8'h01);
		wr_reg(4'h8, 8'h3c);
		wr_reg(4'h8, 8'ha5);
		wr_reg(4'h0, 8'h05);
		wr_reg(4'h8, 8'h5a);
		wait_int;
		rd_chk(4'h0, 8'hff, 8'h01, "control");
		rd_chk(4'h1, 8'h01, 8'h01, "msg done");
		idle(60);
		rd_chk(4'h3, 8'hf0, 8'h60, "rx bad");
		rd_chk(4'h5, 8'hff, 8'h3c, "rx byte");
		wr_reg(4'h0, 8'h00);
		wr_reg(4'h7, 8'hed);
		idle(600);
		rd_chk(4'h4, 8'hff, 8'hed, "rx code");
		rd_chk(4'h1, 8'h80, 8'h80, "code chg");
		wr_reg(4'h0, 8'h10);
		idle(1);
		rd_chk(4'h7, 8'hff, 8'h6d, "tx code");
		wr_reg(4'h0, 8'h00);
		idle(400);
		rd_chk(4'h4, 8'h80, 8'h00, "code gone");
		wr_reg(4'h2, 8'h00);
		idle(4);
		chk("int off", 8'h01, {7'h00, int_n});
		print_verdict;
	end
endmodule // fhbc_controller_bench

//--- dv/fhbc_link_model.sv
`timescale 1ns/1ns
// Framer side: asks for a bit every four (or eight) cycles and loops each
// sent bit back into the receiver, so one packet exercises both paths.
module fhbc_link_model (
	// Clock and reset
	input  wire clk,
	input  wire rst,
	// Pacing
	input  wire slow,
	// Link
	output reg  tx_bit_req,
	input  wire tx_bit,
	output reg  rx_bit_valid,
	output reg  rx_bit
);
	reg [2:0] cnt_q;
	reg       pend_q;
	always @(posedge clk) begin
		if (rst) begin
			cnt_q        <= 3'h0;
			pend_q       <= 1'b0;
			tx_bit_req   <= 1'b0;
			rx_bit_valid <= 1'b0;
			rx_bit       <= 1'b0;
		end else begin
			cnt_q        <= tx_bit_req ? 3'h0 : cnt_q + 3'h1;
			tx_bit_req   <= cnt_q == (slow ? 3'h6 : 3'h2);
			pend_q       <= tx_bit_req;
			rx_bit_valid <= pend_q;
			// Between bits the line toggles so a stale value is never read.
			rx_bit       <= pend_q ? tx_bit : ~rx_bit;
		end
	end
endmodule // fhbc_link_model

//--- hdl/fhbc_controller.v
`timescale 1ns/1ns
`include "fhbc_map.vh"
module fhbc_controller #(
	parameter FIFO_DEPTH = `FHBC_FIFO_DEPTH,
	parameter FIFO_AW    = `FHBC_FIFO_AW
) (
	// Clock and reset
	input  wire       CLK_SYS,
	input  wire       RESET,
	// Parallel register port
	input  wire [3:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	output reg        INT_N,
	// Link bit stream
	input  wire       TX_BIT_REQ,
	output reg        TX_BIT,
	input  wire       RX_BIT_VALID,
	input  wire       RX_BIT
);
	localparam [6:0] S_IDLE  = 7'h01;
	localparam [6:0] S_OPEN  = 7'h02;
	localparam [6:0] S_DATA  = 7'h04;
	localparam [6:0] S_CRC1  = 7'h08;
	localparam [6:0] S_CRC2  = 7'h10;
	localparam [6:0] S_CLOSE = 7'h20;
	localparam [6:0] S_CODE  = 7'h40;
	localparam [FIFO_AW:0] HALF = FIFO_DEPTH / 2;

	function [15:0] crc_step;
		input [15:0] c;
		input        b;
		begin
			crc_step = (c[0] ^ b) ? ((c >> 1) ^ `FHBC_CRC_POLY) : (c >> 1);
		end
	endfunction

	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0]  d;
		integer      i;
		begin
			crc_byte = c;
			for (i = 0; i < 8; i = i + 1)
				crc_byte = crc_step(crc_byte, d[i]);
		end
	endfunction

	reg  [7:0]  ctl_q, ctl_prev_q, mask_q;
	reg  [5:0]  tx_code_q;
	reg         tx_en_q, send_code_q;
	reg         code_chg_q, pkt_end_q, pkt_start_q, msg_done_q;
	reg         under_q, lbd_q;
	reg  [7:0]  rd_mux;
	wire [7:0]  rise = ctl_q & ~ctl_prev_q;
	wire        rx_code_rst = rise[`FHBC_CTL_RX_CODE_RST];
	wire        rx_pkt_rst  = rise[`FHBC_CTL_RX_PKT_RST];
	wire        tx_rst      = rise[`FHBC_CTL_TX_PKT_RST];
	wire        abort_rise  = rise[`FHBC_CTL_ABORT];
	wire        rd_status = RD && (ADDR == `FHBC_ADDR_STATUS);
	wire        rd_rxcode = RD && (ADDR == `FHBC_ADDR_RX_CODE);
	wire        rd_rxfifo = RD && (ADDR == `FHBC_ADDR_RX_FIFO);
	wire        rd_txpkt  = RD && (ADDR == `FHBC_ADDR_TX_PKT);
	wire        wr_txfifo = WR && (ADDR == `FHBC_ADDR_TX_FIFO);

	// Transmit engine state.
	reg  [6:0]  tx_st_q;
	reg  [7:0]  tx_sh_q;
	reg  [2:0]  tx_cnt_q, tx_ones_q;
	reg         tx_stuff_q, tx_eom_q, code_half_q, abort_pend_q;
	reg  [15:0] tx_crc_q;
	reg         ev_done_q, ev_under_q, eom_clr_q;
	reg  [6:0]  nx_st;
	reg  [7:0]  nx_byte;
	reg         nx_pop, nx_under;
	wire        tx_vld, tx_rdy;
	wire [8:0]  tx_dout;
	wire [FIFO_AW:0] tx_lvl;
	wire [15:0] tx_crc_nx = crc_step(tx_crc_q, tx_sh_q[0]);
	wire        tx_ins0 = tx_stuff_q && (tx_ones_q == 3'd5);
	wire        tx_bnd = TX_BIT_REQ && !tx_ins0 && (tx_cnt_q == 3'd7);
	wire        crc_def = ctl_q[`FHBC_CTL_CRC_DEFEAT];
	wire [7:0]  idle_pat = ctl_q[`FHBC_CTL_IDLE_SEL] ? `FHBC_IDLE_BYTE
	                                                 : `FHBC_FLAG_BYTE;

	// Receive engine state.
	reg  [7:0]  rx_sh_q, h0_q, h1_q, h2_q;
	reg  [2:0]  rx_cnt_q, rx_ones_q;
	reg  [1:0]  rx_hcnt_q;
	reg         rx_in_q, rx_first_q, rx_bad_q, rx_push_q;
	reg  [15:0] rx_crc_q;
	reg  [10:0] rx_pdata_q;
	wire        rx_vld, rx_rdy;
	wire [10:0] rx_dout;
	wire [FIFO_AW:0] rx_lvl;
	wire [7:0]  rx_byte = {RX_BIT, rx_sh_q[7:1]};
	wire [7:0]  last_b = (rx_hcnt_q == 2'd3) ? h2_q : 8'h00;
	wire        ev_rps = rx_push_q && rx_pdata_q[8];
	wire        ev_rpe = rx_push_q && rx_pdata_q[9];

	// Received code detector state.
	reg  [15:0] bsh_q;
	reg  [5:0]  cand_q, code_q, gap_q;
	reg         bd_q, ev_chg_q, ev_lbd_q;
	wire [15:0] bnx = {RX_BIT, bsh_q[15:1]};
	wire        bmatch = (bnx[7:0] == 8'hff) && !bnx[8] && !bnx[15];
	wire [7:0]  events = {code_chg_q, pkt_end_q, pkt_start_q, rx_lvl > HALF,
	                      rx_vld, tx_lvl <= HALF, tx_rdy, msg_done_q};

	fhbc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
		.clk(CLK_SYS), .rst(RESET), .flush(tx_rst || abort_rise),
		.in_valid(wr_txfifo), .in_ready(tx_rdy),
		.in_data({ctl_q[`FHBC_CTL_EOM], WDATA}),
		.out_valid(tx_vld), .out_ready(tx_bnd && nx_pop),
		.out_data(tx_dout), .level(tx_lvl));

	fhbc_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
		.clk(CLK_SYS), .rst(RESET), .flush(rx_pkt_rst),
		.in_valid(rx_push_q), .in_ready(rx_rdy), .in_data(rx_pdata_q),
		.out_valid(rx_vld), .out_ready(rd_rxfifo),
		.out_data(rx_dout), .level(rx_lvl));

	// Register file, latched events and interrupt.
	always @(posedge CLK_SYS) begin
		if (RESET) begin
			ctl_q <= `FHBC_CTL_RESET;
			ctl_prev_q <= `FHBC_CTL_RESET;
			mask_q <= `FHBC_MASK_RESET;
			tx_code_q <= 6'h00;
			tx_en_q <= 1'b0;
			send_code_q <= 1'b0;
			{code_chg_q, pkt_end_q, pkt_start_q, msg_done_q} <= 4'h0;
			under_q <= 1'b0;
			lbd_q <= 1'b0;
			RDATA <= 8'h00;
			INT_N <= 1'b1;
		end else begin
			ctl_prev_q <= ctl_q;
			if (WR && ADDR == `FHBC_ADDR_CONTROL)
				ctl_q <= WDATA;
			else if (eom_clr_q)
				ctl_q[`FHBC_CTL_EOM] <= 1'b0;
			if (WR && ADDR == `FHBC_ADDR_MASK)
				mask_q <= WDATA;
			if (WR && ADDR == `FHBC_ADDR_TX_CODE) begin
				tx_code_q <= WDATA[5:0];
				tx_en_q <= WDATA[`FHBC_TXC_ENABLE];
				send_code_q <= WDATA[`FHBC_TXC_SEND];
			end else if (tx_rst)
				send_code_q <= 1'b0;
			// Sets win over the clear that a read of the same bit makes.
			code_chg_q <= ev_chg_q | (code_chg_q & ~rd_status);
			pkt_end_q <= ev_rpe | (pkt_end_q & ~rd_status);
			pkt_start_q <= ev_rps | (pkt_start_q & ~rd_status);
			msg_done_q <= ev_done_q | (msg_done_q & ~rd_status);
			under_q <= ev_under_q | (under_q & ~rd_txpkt);
			lbd_q <= ev_lbd_q | (lbd_q & ~rd_rxcode);
			if (RD)
				RDATA <= rd_mux;
			INT_N <= ~|(events & mask_q);
		end
	end

	always @* begin
		case (ADDR)
		`FHBC_ADDR_CONTROL: rd_mux = ctl_q;
		`FHBC_ADDR_STATUS:  rd_mux = events;
		`FHBC_ADDR_MASK:    rd_mux = mask_q;
		`FHBC_ADDR_RX_PKT:  rd_mux = {~rx_vld, rx_dout[8], rx_dout[9],
		                              rx_dout[10], 4'h0};
		`FHBC_ADDR_RX_CODE: rd_mux = {bd_q, lbd_q, code_q};
		`FHBC_ADDR_RX_FIFO: rd_mux = rx_dout[7:0];
		`FHBC_ADDR_TX_PKT:  rd_mux = {~tx_vld && (tx_st_q == S_IDLE),
		                              ~tx_rdy, under_q, 5'h00};
		`FHBC_ADDR_TX_CODE: rd_mux = {send_code_q, tx_en_q, tx_code_q};
		default:            rd_mux = 8'h00;
		endcase
	end

	// Choice of the next transmitted byte at each byte boundary.
	always @* begin
		nx_st = S_IDLE;
		nx_byte = idle_pat;
		nx_pop = 1'b0;
		nx_under = 1'b0;
		if (abort_pend_q) begin
			nx_byte = `FHBC_ABORT_BYTE;
		end else begin
			case (tx_st_q)
			S_OPEN, S_DATA: begin
				if (tx_st_q == S_DATA && tx_eom_q) begin
					nx_st = crc_def ? S_CLOSE : S_CRC1;
					nx_byte = crc_def ? `FHBC_FLAG_BYTE : ~tx_crc_nx[7:0];
				end else if (tx_vld) begin
					nx_st = S_DATA;
					nx_byte = tx_dout[7:0];
					nx_pop = 1'b1;
				end else begin
					nx_byte = `FHBC_ABORT_BYTE;
					nx_under = 1'b1;
				end
			end
			S_CRC1: begin
				nx_st = S_CRC2;
				nx_byte = ~tx_crc_q[15:8];
			end
			S_CRC2: begin
				nx_st = S_CLOSE;
				nx_byte = `FHBC_FLAG_BYTE;
			end
			default: begin
				if (tx_vld) begin
					nx_st = S_OPEN;
					nx_byte = `FHBC_FLAG_BYTE;
				end else if (send_code_q) begin
					nx_st = S_CODE;
					nx_byte = code_half_q ? {1'b0, tx_code_q, 1'b0}
					                      : `FHBC_IDLE_BYTE;
				end
			end
			endcase
		end
	end

	always @(posedge CLK_SYS) begin
		ev_done_q <= 1'b0;
		ev_under_q <= 1'b0;
		eom_clr_q <= 1'b0;
		if (RESET || tx_rst) begin
			tx_st_q <= S_IDLE;
			tx_sh_q <= `FHBC_FLAG_BYTE;
			tx_cnt_q <= 3'd0;
			tx_ones_q <= 3'd0;
			tx_stuff_q <= 1'b0;
			tx_eom_q <= 1'b0;
			tx_crc_q <= `FHBC_CRC_INIT;
			code_half_q <= 1'b0;
			abort_pend_q <= 1'b0;
			TX_BIT <= 1'b1;
		end else begin
			if (abort_rise)
				abort_pend_q <= 1'b1;
			if (tx_ins0) begin
				if (TX_BIT_REQ) begin
					TX_BIT <= ~tx_en_q;
					tx_ones_q <= 3'd0;
				end
			end else if (TX_BIT_REQ) begin
				TX_BIT <= ~tx_en_q | tx_sh_q[0];
				if (!tx_sh_q[0])
					tx_ones_q <= 3'd0;
				else if (tx_ones_q != 3'd7)
					tx_ones_q <= tx_ones_q + 3'd1;
				if (tx_st_q == S_DATA)
					tx_crc_q <= tx_crc_nx;
				tx_sh_q <= {1'b0, tx_sh_q[7:1]};
				tx_cnt_q <= tx_cnt_q + 3'd1;
			end
			if (tx_bnd) begin
				tx_st_q <= nx_st;
				tx_sh_q <= nx_byte;
				tx_stuff_q <= ~ctl_q[`FHBC_CTL_ZS_DEFEAT] &&
				              (nx_st == S_DATA || nx_st == S_CRC1 ||
				               nx_st == S_CRC2);
				if (nx_pop)
					tx_eom_q <= tx_dout[8];
				if (nx_st == S_OPEN)
					tx_crc_q <= `FHBC_CRC_INIT;
				code_half_q <= (nx_st == S_CODE) && !code_half_q;
				abort_pend_q <= abort_rise;
				eom_clr_q <= (tx_st_q == S_DATA) && tx_eom_q;
				ev_done_q <= (tx_st_q == S_CLOSE) || nx_under;
				ev_under_q <= nx_under && !abort_pend_q;
			end
		end
	end

	// Receive packet engine: flags, aborts, destuffing, byte alignment, CRC.
	always @(posedge CLK_SYS) begin
		rx_push_q <= 1'b0;
		if (RESET || rx_pkt_rst) begin
			rx_sh_q <= 8'h00;
			{h0_q, h1_q, h2_q} <= 24'h000000;
			rx_cnt_q <= 3'd0;
			rx_ones_q <= 3'd0;
			rx_hcnt_q <= 2'd0;
			{rx_in_q, rx_first_q, rx_bad_q} <= 3'b000;
			rx_crc_q <= `FHBC_CRC_INIT;
			rx_pdata_q <= 11'h000;
		end else begin
			if (rx_push_q && !rx_rdy)
				rx_bad_q <= 1'b1;
			if (RX_BIT_VALID) begin
				if (rx_ones_q >= 3'd6) begin
					// Flag or abort closes any packet under way.
					if (rx_in_q && (rx_hcnt_q != 2'd0 || !rx_first_q)) begin
						rx_push_q <= 1'b1;
						rx_pdata_q <= {!RX_BIT && rx_hcnt_q == 2'd3 &&
						  rx_cnt_q == 3'd7 && !rx_bad_q &&
						  rx_crc_q == `FHBC_CRC_GOOD, 1'b1, rx_first_q,
						  last_b};
					end
					rx_in_q <= !RX_BIT;
					rx_ones_q <= RX_BIT ? 3'd7 : 3'd0;
					rx_cnt_q <= 3'd0;
					rx_hcnt_q <= 2'd0;
					rx_first_q <= 1'b1;
					rx_bad_q <= 1'b0;
					rx_crc_q <= `FHBC_CRC_INIT;
				end else if (rx_ones_q == 3'd5 && !RX_BIT) begin
					rx_ones_q <= 3'd0;
				end else begin
					rx_ones_q <= RX_BIT ? rx_ones_q + 3'd1 : 3'd0;
					rx_sh_q <= rx_byte;
					rx_cnt_q <= rx_cnt_q + 3'd1;
					if (rx_in_q && rx_cnt_q == 3'd7) begin
						rx_crc_q <= crc_byte(rx_crc_q, rx_byte);
						{h2_q, h1_q, h0_q} <= {h1_q, h0_q, rx_byte};
						if (rx_hcnt_q == 2'd3) begin
							rx_push_q <= 1'b1;
							rx_pdata_q <= {2'b00, rx_first_q, h2_q};
							rx_first_q <= 1'b0;
						end else
							rx_hcnt_q <= rx_hcnt_q + 2'd1;
					end
				end
			end
		end
	end

	// Received code detector: two equal matches declare, a long gap drops.
	always @(posedge CLK_SYS) begin
		ev_chg_q <= 1'b0;
		ev_lbd_q <= 1'b0;
		if (RESET || rx_code_rst) begin
			bsh_q <= 16'h0000;
			{cand_q, code_q, gap_q} <= 18'h00000;
			bd_q <= 1'b0;
		end else if (RX_BIT_VALID) begin
			bsh_q <= bnx;
			if (bmatch) begin
				gap_q <= 6'h00;
				cand_q <= bnx[14:9];
				if (bnx[14:9] == cand_q && !bd_q) begin
					bd_q <= 1'b1;
					code_q <= cand_q;
					ev_chg_q <= 1'b1;
					ev_lbd_q <= 1'b1;
				end
			end else if (gap_q == `FHBC_CODE_LOSS_BITS) begin
				if (bd_q) begin
					bd_q <= 1'b0;
					ev_chg_q <= 1'b1;
				end
			end else
				gap_q <= gap_q + 6'h01;
		end
	end
endmodule // fhbc_controller

//--- hdl/fhbc_fifo.v
`timescale 1ns/1ns
// Pointers wrap naturally, so DEPTH must be a power of two.
module fhbc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	input  wire             flush,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0]      level
);
	localparam [AW:0] FULL = DEPTH;

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wp_q;
	reg [AW-1:0]    rp_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;

	assign in_ready  = (cnt_q != FULL);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rp_q];
	assign level     = cnt_q;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always @(posedge clk) begin
		if (push)
			mem[wp_q] <= in_data;
	end

	always @(posedge clk) begin
		if (rst || flush) begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // fhbc_fifo

//--- hdl/fhbc_map.vh
`ifndef FHBC_MAP_VH
`define FHBC_MAP_VH

`define FHBC_ADDR_W         4
`define FHBC_ADDR_CONTROL   4'h0
`define FHBC_ADDR_STATUS    4'h1
`define FHBC_ADDR_MASK      4'h2
`define FHBC_ADDR_RX_PKT    4'h3
`define FHBC_ADDR_RX_CODE   4'h4
`define FHBC_ADDR_RX_FIFO   4'h5
`define FHBC_ADDR_TX_PKT    4'h6
`define FHBC_ADDR_TX_CODE   4'h7
`define FHBC_ADDR_TX_FIFO   4'h8

`define FHBC_CTL_RX_CODE_RST  7
`define FHBC_CTL_RX_PKT_RST   6
`define FHBC_CTL_IDLE_SEL     5
`define FHBC_CTL_TX_PKT_RST   4
`define FHBC_CTL_ABORT        3
`define FHBC_CTL_EOM          2
`define FHBC_CTL_ZS_DEFEAT    1
`define FHBC_CTL_CRC_DEFEAT   0
`define FHBC_CTL_RESET        8'h00
`define FHBC_MASK_RESET       8'h00

`define FHBC_TXC_SEND         7
`define FHBC_TXC_ENABLE       6

`define FHBC_FLAG_BYTE        8'h7e
`define FHBC_IDLE_BYTE        8'hff
`define FHBC_ABORT_BYTE       8'hfe
`define FHBC_CRC_INIT         16'hffff
`define FHBC_CRC_POLY         16'h8408
`define FHBC_CRC_GOOD         16'hf0b8
`define FHBC_CODE_LOSS_BITS   6'h28
`define FHBC_FIFO_DEPTH       4
`define FHBC_FIFO_AW          2

`endif
